// ==== design/rsi_pkg.sv ====
package rsi_pkg;

    // ------------------------------------------------------------------
    // Sizes of the register groups
    // ------------------------------------------------------------------
    localparam int NUM_PORTS = 11;
    localparam int NUM_DIR = 9;
    localparam int NUM_PU = 9;
    localparam int NUM_TMR = 20;

    // Port latch index of port two and of the indicator pin
    localparam int PORT_TWO_IDX = 2;
    localparam int IND_PORT_IDX = 9;
    localparam int IND_BIT = 0;

    // Timer byte file layout
    localparam int TMR_WIDE_CNT = 0;
    localparam int TMR_CAPTURE = 4;
    localparam int TMR_NARROW_CNT = 12;
    localparam int TMR_NARROW_CMP = 14;
    localparam int TMR_INTERVAL_CMP = 16;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_BASE = 8'h00;
    localparam logic [7:0] ADDR_DIR_BASE = 8'h10;
    localparam logic [7:0] ADDR_PU_BASE = 8'h20;
    localparam logic [7:0] ADDR_SETTLE = 8'h30;
    localparam logic [7:0] ADDR_WAIT = 8'h31;
    localparam logic [7:0] ADDR_XRAM = 8'h32;
    localparam logic [7:0] ADDR_WATCH = 8'h33;
    localparam logic [7:0] ADDR_CARRIER = 8'h34;
    localparam logic [7:0] ADDR_STATUS = 8'h35;
    localparam logic [7:0] ADDR_PC_LO = 8'h36;
    localparam logic [7:0] ADDR_PC_HI = 8'h37;
    localparam logic [7:0] ADDR_TMR_BASE = 8'h40;

    // Status register bits
    localparam int STAT_WDT_CAUSE = 0;
    localparam int STAT_RAM_KEPT = 1;
    localparam int STAT_PC_VALID = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] PU_RST = 8'h00;
    localparam logic [7:0] SETTLE_RST = 8'h05;
    localparam logic [7:0] WAIT_RST = 8'h10;
    localparam logic [7:0] XRAM_RST = 8'h0c;
    localparam logic [7:0] WATCH_RST = 8'h00;
    localparam logic [7:0] CARRIER_RST = 8'h00;
    localparam logic [7:0] TMR_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint CLK_FREQ_HZ = 125_000_000;
    localparam longint INTERNAL_OSC_FREQ_HZ = 8_000_000;
    localparam longint STALL_OSC_PERIODS = 17;
    localparam int STALL_CYCLES = int'((STALL_OSC_PERIODS * CLK_FREQ_HZ
        + INTERNAL_OSC_FREQ_HZ - 1) / INTERNAL_OSC_FREQ_HZ);
    localparam int STALL_W = 9;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {PH_RUN, PH_HOLD, PH_STALL} rsi_phase_t;

    typedef struct packed {
        logic wdt_overflow;
        logic clk_monitor_stop;
        logic poc_detect;
        logic lvi_detect;
    } rsi_src_t;

    typedef struct packed {
        logic [NUM_PORTS-1:0][7:0] port_latch;
        logic [NUM_DIR-1:0][7:0] port_dir;
        logic [NUM_PU-1:0][7:0] pull_up;
        logic [7:0] osc_settle_time_select;
        logic [7:0] mem_expansion_wait_cfg;
        logic [7:0] expansion_ram_size_cfg;
        logic [7:0] watch_timer_mode_reg;
        logic [7:0] carrier_control_reg;
        logic [NUM_TMR-1:0][7:0] timer_bytes;
    } rsi_cfg_t;

    typedef struct packed {
        rsi_phase_t phase;
        logic [STALL_W-1:0] stall_cnt;
        rsi_cfg_t cfg;
        logic [15:0] program_counter;
        logic pc_valid;
        logic wdt_cause;
        logic wdt_clear;
        logic ram_preserve;
        logic reset_indicator_pin;
        logic cpu_clk_run;
        logic core_reset;
        logic [7:0] rdata;
    } rsi_state_t;

endpackage : rsi_pkg

// ==== design/rsi_reset_combiner.sv ====
`timescale 1ns/1ps

module rsi_reset_combiner
    import rsi_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Reset sources
    input wire logic reset_pin_n_i,
    input wire rsi_src_t src_i,
    // Combined request
    output logic req_o,
    output logic wdt_o
);

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    // Both stages reset high so the pin reads released after rst_i
    logic pin_meta_reg;
    logic pin_sync_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
        end else begin
            pin_meta_reg <= reset_pin_n_i;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // One internal reset line
    // ------------------------------------------------------------------
    always_comb begin
        req_o = !pin_sync_reg || (|src_i);
        wdt_o = src_i.wdt_overflow;
    end

endmodule : rsi_reset_combiner

// ==== design/rsi_reset_state_initializer.sv ====
`timescale 1ns/1ps

module rsi_reset_state_initializer
    import rsi_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Reset sources
    input wire logic reset_pin_n_i,
    input wire rsi_src_t src_i,
    // Device context
    input wire logic standby_i,
    input wire logic [15:0] reset_vector_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Reset state outputs
    output logic reset_indicator_pin_o,
    output logic core_reset_o,
    output logic cpu_clk_run_o,
    output logic wdt_clear_o,
    output logic ram_preserve_o,
    output logic [15:0] program_counter_o,
    output logic pc_valid_o,
    output rsi_cfg_t cfg_o
);

    // ------------------------------------------------------------------
    // Reset source combining
    // ------------------------------------------------------------------
    logic req;
    logic wdt_req;

    rsi_reset_combiner i_rsi_reset_combiner (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .reset_pin_n_i(reset_pin_n_i),
        .src_i(src_i),
        .req_o(req),
        .wdt_o(wdt_req)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    rsi_state_t s_reg;
    rsi_state_t s_next;

    function automatic logic in_win(input logic [7:0] a,
                                    input logic [7:0] base,
                                    input logic [7:0] n);
        logic [7:0] d;
        d = a - base;
        return (a >= base) && (d < n);
    endfunction : in_win

    // Initial values for every register; port two keeps its latch
    function automatic rsi_cfg_t reset_cfg(input rsi_cfg_t cur);
        rsi_cfg_t c;
        c = cur;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (i != PORT_TWO_IDX) begin
                c.port_latch[i] = PORT_RST;
            end
        end
        for (int i = 0; i < NUM_DIR; i++) begin
            c.port_dir[i] = DIR_RST;
        end
        for (int i = 0; i < NUM_PU; i++) begin
            c.pull_up[i] = PU_RST;
        end
        c.osc_settle_time_select = SETTLE_RST;
        c.mem_expansion_wait_cfg = WAIT_RST;
        c.expansion_ram_size_cfg = XRAM_RST;
        for (int i = 0; i < NUM_TMR; i++) begin
            c.timer_bytes[i] = TMR_RST;
        end
        c.carrier_control_reg = CARRIER_RST;
        c.watch_timer_mode_reg = WATCH_RST;
        return c;
    endfunction : reset_cfg

    always_comb begin
        logic [7:0] off;
        logic [7:0] status;
        off = 8'h00;
        status = 8'h00;
        s_next = s_reg;
        s_next.wdt_clear = 1'b0;
        s_next.rdata = 8'h00;

        // --------------------------------------------------------------
        // Register reads, always answered, unmapped reads zero
        // --------------------------------------------------------------
        status[STAT_WDT_CAUSE] = s_reg.wdt_cause;
        status[STAT_RAM_KEPT] = s_reg.ram_preserve;
        status[STAT_PC_VALID] = s_reg.pc_valid;
        if (rd_i) begin
            if (in_win(addr_i, ADDR_PORT_BASE, 8'(NUM_PORTS))) begin
                off = addr_i - ADDR_PORT_BASE;
                s_next.rdata = s_reg.cfg.port_latch[off];
            end else if (in_win(addr_i, ADDR_DIR_BASE, 8'(NUM_DIR))) begin
                off = addr_i - ADDR_DIR_BASE;
                s_next.rdata = s_reg.cfg.port_dir[off];
            end else if (in_win(addr_i, ADDR_PU_BASE, 8'(NUM_PU))) begin
                off = addr_i - ADDR_PU_BASE;
                s_next.rdata = s_reg.cfg.pull_up[off];
            end else if (in_win(addr_i, ADDR_TMR_BASE, 8'(NUM_TMR))) begin
                off = addr_i - ADDR_TMR_BASE;
                s_next.rdata = s_reg.cfg.timer_bytes[off];
            end else begin
                case (addr_i)
                    ADDR_SETTLE: s_next.rdata =
                        s_reg.cfg.osc_settle_time_select;
                    ADDR_WAIT: s_next.rdata = s_reg.cfg.mem_expansion_wait_cfg;
                    ADDR_XRAM: s_next.rdata = s_reg.cfg.expansion_ram_size_cfg;
                    ADDR_WATCH: s_next.rdata = s_reg.cfg.watch_timer_mode_reg;
                    ADDR_CARRIER: s_next.rdata =
                        s_reg.cfg.carrier_control_reg;
                    ADDR_STATUS: s_next.rdata = status;
                    ADDR_PC_LO: s_next.rdata = s_reg.program_counter[7:0];
                    ADDR_PC_HI: s_next.rdata = s_reg.program_counter[15:8];
                    default: s_next.rdata = 8'h00;
                endcase
            end
        end

        // --------------------------------------------------------------
        // Register writes, only while the core runs
        // --------------------------------------------------------------
        // Writes during reset or the stall are dropped so the held
        // initial values cannot be disturbed before execution starts
        if (wr_i && !req && s_reg.phase == PH_RUN) begin
            if (in_win(addr_i, ADDR_PORT_BASE, 8'(NUM_PORTS))) begin
                off = addr_i - ADDR_PORT_BASE;
                s_next.cfg.port_latch[off] = wdata_i;
            end else if (in_win(addr_i, ADDR_DIR_BASE, 8'(NUM_DIR))) begin
                off = addr_i - ADDR_DIR_BASE;
                s_next.cfg.port_dir[off] = wdata_i;
            end else if (in_win(addr_i, ADDR_PU_BASE, 8'(NUM_PU))) begin
                off = addr_i - ADDR_PU_BASE;
                s_next.cfg.pull_up[off] = wdata_i;
            end else if (in_win(addr_i, ADDR_TMR_BASE, 8'(NUM_TMR))) begin
                off = addr_i - ADDR_TMR_BASE;
                s_next.cfg.timer_bytes[off] = wdata_i;
            end else begin
                case (addr_i)
                    ADDR_SETTLE: s_next.cfg.osc_settle_time_select = wdata_i;
                    ADDR_WAIT: s_next.cfg.mem_expansion_wait_cfg = wdata_i;
                    ADDR_XRAM: s_next.cfg.expansion_ram_size_cfg = wdata_i;
                    ADDR_WATCH: s_next.cfg.watch_timer_mode_reg = wdata_i;
                    ADDR_CARRIER: s_next.cfg.carrier_control_reg = wdata_i;
                    default: ;
                endcase
            end
        end

        // --------------------------------------------------------------
        // Reset sequencing
        // --------------------------------------------------------------
        case (s_reg.phase)
            PH_RUN: ;
            PH_HOLD: begin
                if (!req) begin
                    s_next.phase = PH_STALL;
                    s_next.stall_cnt = '0;
                end
            end
            PH_STALL: begin
                if (s_reg.stall_cnt == STALL_W'(STALL_CYCLES - 1)) begin
                    s_next.phase = PH_RUN;
                    s_next.program_counter = reset_vector_i;
                    s_next.pc_valid = 1'b1;
                end else begin
                    s_next.stall_cnt = s_reg.stall_cnt + 1'b1;
                end
            end
            default: s_next.phase = PH_HOLD;
        endcase

        // A request in any phase restarts the whole sequence
        if (req) begin
            s_next.cfg = reset_cfg(s_reg.cfg);
            s_next.phase = PH_HOLD;
            s_next.stall_cnt = '0;
            s_next.pc_valid = 1'b0;
            if (s_reg.phase == PH_RUN) begin
                s_next.wdt_cause = wdt_req;
                s_next.wdt_clear = wdt_req;
                s_next.ram_preserve = standby_i;
            end
        end

        // Pin outputs follow the phase being entered
        s_next.core_reset = (s_next.phase != PH_RUN);
        s_next.cpu_clk_run = (s_next.phase == PH_RUN);
        s_next.reset_indicator_pin = (s_next.phase == PH_RUN) &&
            s_next.cfg.port_latch[IND_PORT_IDX][IND_BIT];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg.phase <= PH_HOLD;
            s_reg.stall_cnt <= '0;
            s_reg.cfg.port_latch <= '0;
            s_reg.cfg.port_dir <= {NUM_DIR{DIR_RST}};
            s_reg.cfg.pull_up <= {NUM_PU{PU_RST}};
            s_reg.cfg.osc_settle_time_select <= SETTLE_RST;
            s_reg.cfg.mem_expansion_wait_cfg <= WAIT_RST;
            s_reg.cfg.expansion_ram_size_cfg <= XRAM_RST;
            s_reg.cfg.watch_timer_mode_reg <= WATCH_RST;
            s_reg.cfg.carrier_control_reg <= CARRIER_RST;
            s_reg.cfg.timer_bytes <= {NUM_TMR{TMR_RST}};
            s_reg.program_counter <= PC_RST;
            s_reg.pc_valid <= 1'b0;
            s_reg.wdt_cause <= 1'b0;
            s_reg.wdt_clear <= 1'b0;
            s_reg.ram_preserve <= 1'b0;
            s_reg.reset_indicator_pin <= 1'b0;
            s_reg.cpu_clk_run <= 1'b0;
            s_reg.core_reset <= 1'b1;
            s_reg.rdata <= 8'h00;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_o = s_reg.rdata;
    assign reset_indicator_pin_o = s_reg.reset_indicator_pin;
    assign core_reset_o = s_reg.core_reset;
    assign cpu_clk_run_o = s_reg.cpu_clk_run;
    assign wdt_clear_o = s_reg.wdt_clear;
    assign ram_preserve_o = s_reg.ram_preserve;
    assign program_counter_o = s_reg.program_counter;
    assign pc_valid_o = s_reg.pc_valid;
    assign cfg_o = s_reg.cfg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    localparam int STALL_N = STALL_CYCLES;

    logic [STALL_W:0] stop_cnt_h;
    always_ff @(posedge clk_i) begin
        if (rst_i || s_reg.phase != PH_STALL) begin
            stop_cnt_h <= '0;
        end else begin
            stop_cnt_h <= stop_cnt_h + 1'b1;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ack;
        req && s_reg.phase == PH_RUN;
    endsequence

    sequence s_stall_end;
        s_reg.phase == PH_STALL && !req &&
            s_reg.stall_cnt == STALL_W'(STALL_CYCLES - 1);
    endsequence

    ind_low_a: assert property (core_reset_o |-> !reset_indicator_pin_o)
        else $error("indicator pin high during reset");

    ind_fall_a: assert property ((reset_indicator_pin_o && req) |=>
        $fell(reset_indicator_pin_o))
        else $error("indicator pin did not fall at reset");

    wdt_clear_a: assert property ((s_ack and wdt_req) |=>
        wdt_clear_o ##1 !wdt_clear_o)
        else $error("watchdog clear pulse wrong");

    pc_load_a: assert property (s_stall_end |=>
        (program_counter_o == $past(reset_vector_i)) && pc_valid_o &&
        cpu_clk_run_o)
        else $error("program counter not loaded from vector");

    pc_undef_a: assert property (core_reset_o |-> !pc_valid_o)
        else $error("program counter valid during reset");

    ram_keep_a: assert property (s_ack |=>
        ram_preserve_o == $past(standby_i))
        else $error("RAM preserve flag not taken from standby");

    port_two_a: assert property (req |=>
        cfg_o.port_latch[PORT_TWO_IDX] ==
        $past(cfg_o.port_latch[PORT_TWO_IDX]) &&
        cfg_o.port_latch[IND_PORT_IDX] == PORT_RST)
        else $error("port latch reset wrong");

    dir_ones_a: assert property (req |=>
        cfg_o.port_dir == {NUM_DIR{DIR_RST}})
        else $error("port direction not all inputs");

    pullup_off_a: assert property (req |=>
        cfg_o.pull_up == {NUM_PU{PU_RST}})
        else $error("pull-ups not cleared");

    cfg_init_a: assert property (req |=>
        cfg_o.osc_settle_time_select == SETTLE_RST &&
        cfg_o.mem_expansion_wait_cfg == WAIT_RST &&
        cfg_o.expansion_ram_size_cfg == XRAM_RST)
        else $error("memory or oscillator setting wrong");

    timer_clear_a: assert property (req |=>
        cfg_o.timer_bytes == {NUM_TMR{TMR_RST}} &&
        cfg_o.carrier_control_reg == CARRIER_RST)
        else $error("timer registers not cleared");

    watch_stop_a: assert property (core_reset_o |->
        cfg_o.watch_timer_mode_reg == WATCH_RST)
        else $error("watch timer mode not cleared");

    stall_len_a: assert property ($rose(cpu_clk_run_o) |->
        $past(stop_cnt_h) == (STALL_W + 1)'(STALL_N - 1))
        else $error("CPU clock stall length wrong");

    stall_hold_a: assert property (s_ack |=>
        (!cpu_clk_run_o && core_reset_o)[*8])
        else $error("CPU clock ran too early");

    one_reset_a: assert property (s_ack |=> core_reset_o &&
        !cpu_clk_run_o && cfg_o.osc_settle_time_select == SETTLE_RST &&
        cfg_o.watch_timer_mode_reg == WATCH_RST)
        else $error("reset values not applied together");

endmodule : rsi_reset_state_initializer

// ==== dv/rsi_reset_state_initializer_bench.sv ====
`timescale 1ns/1ps

module rsi_reset_state_initializer_bench;
    import rsi_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic reset_pin_n_i = 1'b1;
    rsi_src_t src_i = '0;
    logic standby_i = 1'b0;
    logic [15:0] reset_vector_i = 16'ha5c3;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic reset_indicator_pin_o;
    logic core_reset_o;
    logic cpu_clk_run_o;
    logic wdt_clear_o;
    logic ram_preserve_o;
    logic [15:0] program_counter_o;
    logic pc_valid_o;
    rsi_cfg_t cfg_o;
    int n_errors = 0;
    int check_count = 0;
    int n;
    logic [7:0] d;

    rsi_reset_state_initializer i_rsi_reset_state_initializer (
        .clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i),
        .src_i(src_i), .standby_i(standby_i),
        .reset_vector_i(reset_vector_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .reset_indicator_pin_o(reset_indicator_pin_o),
        .core_reset_o(core_reset_o), .cpu_clk_run_o(cpu_clk_run_o),
        .wdt_clear_o(wdt_clear_o), .ram_preserve_o(ram_preserve_o),
        .program_counter_o(program_counter_o), .pc_valid_o(pc_valid_o),
        .cfg_o(cfg_o)
    );

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic conclude;
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : rd

    // Counts edges until the CPU clock runs; a hang ends the run
    task automatic wait_run(output int cnt);
        for (cnt = 1; cnt < 3000; cnt++) begin
            @(posedge clk_i);
            #1;
            if (cpu_clk_run_o === 1'b1) begin
                return;
            end
        end
        n_errors++;
        conclude();
    endtask : wait_run

    function automatic logic [7:0] exp_val(logic [7:0] a, bit after);
        logic mapped;
        mapped = a <= 8'h0a || (a >= 8'h10 && a <= 8'h18)
            || (a >= 8'h20 && a <= 8'h28) || (a >= 8'h30 && a <= 8'h34)
            || (a >= 8'h40 && a <= 8'h53);
        if (!mapped) return 8'h00;
        if (!after || a == 8'h02) return a ^ 8'h96;
        if (a <= 8'h0a || (a >= 8'h20 && a <= 8'h28)) return 8'h00;
        if (a <= 8'h18) return 8'hff;
        if (a == 8'h30) return 8'h05;
        if (a == 8'h31) return 8'h10;
        if (a == 8'h32) return 8'h0c;
        return 8'h00;
    endfunction : exp_val

    task automatic chk_all(input bit after);
        logic [7:0] v;
        logic [7:0] e;
        for (int a = 0; a < 8'h60; a++) begin
            if (a < 8'h35 || a > 8'h37) begin
                rd(a[7:0], v);
                e = exp_val(a[7:0], after);
                chk(v, e);
            end
        end
    endtask : chk_all

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk(core_reset_o, 1'b1);
        wait_run(n);
        chk(program_counter_o, 16'ha5c3);
        chk(pc_valid_o, 1'b1);
        for (int a = 0; a < 8'h60; a++) begin
            if (a < 8'h35 || a > 8'h37) wr(a[7:0], a[7:0] ^ 8'h96);
        end
        #1 chk(reset_indicator_pin_o, 1'b1);
        chk_all(1'b0);
        // Watchdog source pulsed for one cycle
        @(posedge clk_i);
        src_i.wdt_overflow <= 1'b1;
        @(posedge clk_i);
        src_i.wdt_overflow <= 1'b0;
        #1 chk(reset_indicator_pin_o, 1'b0);
        chk(wdt_clear_o, 1'b1);
        chk(cpu_clk_run_o, 1'b0);
        chk(pc_valid_o, 1'b0);
        chk(cfg_o.osc_settle_time_select, 8'h05);
        wait_run(n);
        chk(n, 267);
        chk(program_counter_o, 16'ha5c3);
        chk(ram_preserve_o, 1'b0);
        chk(reset_indicator_pin_o, 1'b0);
        chk_all(1'b1);
        rd(8'h35, d);
        chk(d, 8'h05);
        rd(8'h36, d);
        chk(d, 8'hc3);
        rd(8'h37, d);
        chk(d, 8'ha5);
        // Pin reset out of standby; writes in reset are dropped
        wr(8'h09, 8'h01);
        standby_i <= 1'b1;
        reset_pin_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1 chk(reset_indicator_pin_o, 1'b0);
        chk(wdt_clear_o, 1'b0);
        chk(ram_preserve_o, 1'b1);
        wr(8'h30, 8'hee);
        rd(8'h30, d);
        chk(d, 8'h05);
        repeat (1250) @(posedge clk_i);
        reset_pin_n_i <= 1'b1;
        standby_i <= 1'b0;
        wait_run(n);
        chk(ram_preserve_o, 1'b1);
        rd(8'h35, d);
        chk(d, 8'h06);
        // Remaining sources each join the same internal reset
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i);
            src_i <= rsi_src_t'(4'h1 << k);
            @(posedge clk_i);
            src_i <= '0;
            #1 chk(core_reset_o, 1'b1);
            chk(wdt_clear_o, 1'b0);
            wait_run(n);
            chk(n, 267);
        end
        conclude();
    end

endmodule : rsi_reset_state_initializer_bench
